// file: bench/iop_pads.sv
// Pad model of the pins and outside sources around the port block
`timescale 1ns/10ps

module iop_pads (
  // Clock
  input  wire logic        mclk,
  // Block side
  input  wire logic [12:0] pad_out,
  input  wire logic [12:0] pad_oe,
  input  wire logic [12:0] pull_en,
  // Outside sources
  input  wire logic [12:0] ext_en,
  input  wire logic [12:0] ext_val,
  // Levels at the pads
  output      logic [12:0] pad_in
);
  logic [12:0] last_r = '0;

  // Last level, so a floating line wanders instead of holding still
  always @(posedge mclk) begin
    last_r <= pad_in;
  end

  // Block driver wins, then outside source, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pull_en[i] ? 1'b1 : ~last_r[i];
    end
  end
endmodule : iop_pads

// file: bench/test_iop_top.sv
// Self-checking testbench of the I/O port block
`timescale 1ns/10ps
`include "iop_defines.svh"

module test_iop_top
  import iop_pkg::*;
;
  // -------------------------------------------
  // Signals
  // -------------------------------------------
  localparam logic [12:0] PULL      = 13'h0FF0;
  localparam logic [7:0]  MASK  [3] = '{8'hFF, 8'h0F, 8'h01};
  localparam logic [7:0]  AD    [3] = '{8'h12, 8'h14, 8'h18};
  localparam logic [7:0]  AC    [3] = '{8'h13, 8'h15, 8'h19};
  logic        mclk, rst, tone_opt, pwm_opt, timer_ovf, halted, wake, irq_pin, tmr_pin;
  logic        t, seen;
  iop_req_t    req;
  logic [7:0]  rdata, got, duty;
  logic [7:0]  lat_m [3];
  logic [7:0]  dir_m [3];
  logic [12:0] pad_in, pad_out, pad_oe, pull_en, ext_en, ext_val, n;
  int          fails, check_count, cycles;

  iop_top #(.PULL_OPT(PULL)) iop_top_inst (
    .mclk(mclk), .rst(rst), .ce(1'b1), .req(req), .rdata(rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en), .tone_opt(tone_opt),
    .pwm_opt(pwm_opt), .timer_ovf(timer_ovf), .halted(halted), .wake(wake),
    .irq_shared_pin(irq_pin), .timer_clock_shared_pin(tmr_pin));

  iop_pads iop_pads_inst (
    .mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_en(pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // -------------------------------------------
  // Clock, hang guard, helpers
  // -------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Ceiling well above the roughly 2000 cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  // One request held across its taking edge, then a cycle for the answer
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
                        input logic r, input iop_op_t o, input logic [2:0] s);
    req = '{addr: a, wdata: d, wr: w, rd: r, op: o, bit_sel: s};
    tick(1);
    req = '0;
    tick(1);
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(a, d, 1'b1, 1'b0, IOP_OP_NONE, 3'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    access(a, 8'h00, 1'b0, 1'b1, IOP_OP_NONE, 3'h0);
    got = rdata;
  endtask : rd

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic [12:0] g, input logic [12:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_pin

  function automatic logic [12:0] join3(input logic [7:0] a, input logic [7:0] b,
                                        input logic [7:0] d);
    return {d[0], b[3:0], a};
  endfunction : join3

  // Expected read: pad level for input lines, latch for output lines
  function automatic logic [7:0] exp_rd(input int p);
    logic [12:0] pin;
    logic [7:0]  v;
    pin = (ext_en & ext_val) | ~ext_en;
    v = (p == 0) ? pin[7:0] : (p == 1) ? {4'h0, pin[11:8]} : {7'h00, pin[12]};
    return (dir_m[p] & v) | (~dir_m[p] & lat_m[p]);
  endfunction : exp_rd

  function automatic logic [7:0] bitop(input logic [7:0] v, input iop_op_t o,
                                       input logic [2:0] s);
    case (o)
      IOP_OP_SET: return v | (8'h01 << s);
      IOP_OP_CLR: return v & ~(8'h01 << s);
      default:    return ~v;
    endcase
  endfunction : bitop

  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial begin
    rst = 1'b1; req = '0; tone_opt = 1'b0; pwm_opt = 1'b0; timer_ovf = 1'b0;
    halted = 1'b0; ext_en = ~PULL; ext_val = '0; fails = 0; check_count = 0;
    cycles = 0; t = 1'b0;
    void'($urandom(60680));
    tick(2);
    rst = 1'b0;
    // Pads need two synchroniser stages before the first read sees them
    tick(3);
    // Reset state, address map, missing bits, unmapped place
    cmp_pin(pad_oe, 13'h0000);
    cmp_pin(pull_en, PULL);
    for (int p = 0; p < 3; p++) begin
      lat_m[p] = MASK[p];
      dir_m[p] = MASK[p];
      rd(AD[p]);
      cmp_reg(got, exp_rd(p));
      rd(AC[p]);
      cmp_reg(got, MASK[p]);
    end
    wr(8'h16, 8'h5A);
    rd(8'h16);
    cmp_reg(got, 8'h00);
    // Random directions, latches and outside levels; first pass all outputs
    for (int k = 0; k < 10; k++) begin
      ext_val = 13'($urandom);
      ext_en = 13'($urandom) | ~PULL;
      for (int p = 0; p < 3; p++) begin
        dir_m[p] = (k == 0) ? 8'h00 : 8'($urandom);
        lat_m[p] = 8'($urandom);
        wr(AC[p], dir_m[p]);
        wr(AD[p], lat_m[p]);
        dir_m[p] &= MASK[p];
        lat_m[p] &= MASK[p];
      end
      tick(3);
      n = ~join3(dir_m[0], dir_m[1], dir_m[2]);
      cmp_pin(pad_oe, n);
      cmp_pin(pad_out & n, join3(lat_m[0], lat_m[1], lat_m[2]) & n);
      for (int p = 0; p < 3; p++) begin
        rd(AD[p]);
        cmp_reg(got, exp_rd(p));
        rd(AC[p]);
        cmp_reg(got, dir_m[p]);
      end
    end
    // Set, clear, complement back to back on port A
    for (int k = 0; k < 6; k++) begin
      duty = 8'($urandom);
      lat_m[0] = bitop(exp_rd(0), iop_op_t'(k % 3 + 1), duty[2:0]);
      access(AD[0], 8'h00, 1'b0, 1'b0, iop_op_t'(k % 3 + 1), duty[2:0]);
    end
    rd(AD[0]);
    cmp_reg(got, exp_rd(0));
    dir_m[0] = 8'h00;
    wr(AC[0], 8'h00);
    rd(AD[0]);
    cmp_reg(got, lat_m[0]);
    // Tone on port A bit 3, gated by its latch
    tone_opt = 1'b1;
    wr(AD[0], 8'h08);
    for (int k = 0; k < 4; k++) begin
      timer_ovf = 1'b1;
      tick(1);
      timer_ovf = 1'b0;
      t = ~t;
      tick(3);
      cmp_pin(13'(pad_out[3]), 13'(t));
    end
    wr(AD[0], 8'h00);
    tick(2);
    cmp_pin(13'(pad_out[3]), 13'h0000);
    // Input mode on every port A line: shared pins and wake-up
    wr(AC[0], 8'hFF);
    ext_en[7:0] = 8'hFF;
    tick(6);
    for (int k = 0; k < 4; k++) begin
      ext_val[5:4] = 2'(k);
      tick(4);
      cmp_pin(13'({irq_pin, tmr_pin}), 13'(k));
    end
    for (int k = 0; k < 9; k++) begin
      halted = (k < 8);
      ext_val[k % 8] = ~ext_val[k % 8];
      seen = 1'b0;
      repeat (6) begin
        tick(1);
        seen = seen | wake;
      end
      cmp_pin(13'(seen), 13'(k < 8));
    end
    // Pulse width on port D bit 0: high total per full cycle equals duty
    halted = 1'b0;
    pwm_opt = 1'b1;
    wr(AC[2], 8'h00);
    wr(AD[2], 8'h01);
    for (int k = 0; k < 6; k++) begin
      duty = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : (k == 2) ? 8'h41 : 8'($urandom);
      wr(`IOP_ADDR_DUTY, duty);
      if (k == 5) begin
        wr(AD[2], 8'h00);
      end
      tick(8);
      n = '0;
      repeat (256) begin
        n = n + 13'(pad_out[12]);
        tick(1);
      end
      cmp_pin(n, (k == 5) ? 13'h0000 : 13'(duty));
    end
    rd(`IOP_ADDR_DUTY);
    cmp_reg(got, duty);
    give_verdict();
  end
endmodule : test_iop_top

// file: logic/iop_defines.svh
// Address map, field positions and reset values of the I/O port block
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH

// ----------------------------------------
// Data-memory addresses
// ----------------------------------------
`define IOP_ADDR_PA_DATA 8'h12
`define IOP_ADDR_PA_DIR  8'h13
`define IOP_ADDR_PB_DATA 8'h14
`define IOP_ADDR_PB_DIR  8'h15
`define IOP_ADDR_PD_DATA 8'h18
`define IOP_ADDR_PD_DIR  8'h19
`define IOP_ADDR_DUTY    8'h1A

// ----------------------------------------
// Line layout on the pad vectors
// ----------------------------------------
`define IOP_NLINES     13
`define IOP_PB_W       4
`define IOP_PD_W       1
`define IOP_PA_HI      7
`define IOP_PB_LO      8
`define IOP_PB_HI      11
`define IOP_PD_BIT     12
`define IOP_TONE_BIT   3
`define IOP_TMRCLK_BIT 4
`define IOP_IRQ_BIT    5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOP_PA_RST   8'hFF
`define IOP_PB_RST   4'hF
`define IOP_PD_RST   1'h1
`define IOP_DUTY_RST 8'h00
`define IOP_ZERO8    8'h00

// ----------------------------------------
// Pulse-width timing
// ----------------------------------------
`define IOP_POS_W   6
`define IOP_MCYC_W  2
`define IOP_POS_TOP 6'h3F
`define IOP_CNT_TOP 8'hFF

`endif

// file: logic/iop_pkg.sv
// Types shared by the I/O port block and its pulse-width generator
`include "iop_defines.svh"

package iop_pkg;

  // ----------------------------------------
  // Core access
  // ----------------------------------------
  typedef enum logic [1:0] {
    IOP_OP_NONE = 2'b00,
    IOP_OP_SET  = 2'b01,
    IOP_OP_CLR  = 2'b10,
    IOP_OP_CPL  = 2'b11
  } iop_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    iop_op_t    op;
    logic [2:0] bit_sel;
  } iop_req_t;

  // ----------------------------------------
  // Module state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]              pa_d;
    logic [7:0]              pa_c;
    logic [`IOP_PB_W-1:0]    pb_d;
    logic [`IOP_PB_W-1:0]    pb_c;
    logic [`IOP_PD_W-1:0]    pd_d;
    logic [`IOP_PD_W-1:0]    pd_c;
    logic [7:0]              duty;
    logic [`IOP_NLINES-1:0]  sync1;
    logic [`IOP_NLINES-1:0]  sync2;
    logic [7:0]              pa_prev;
    logic                    tone;
    logic [7:0]              rdata;
    logic [`IOP_NLINES-1:0]  out;
    logic [`IOP_NLINES-1:0]  oe;
    logic [`IOP_NLINES-1:0]  pull;
    logic                    wake;
    logic                    irq;
    logic                    tmr;
  } iop_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } iop_pwm_state_t;

endpackage : iop_pkg

// file: logic/iop_pwm.sv
// Six-plus-two bit pulse-width generator on the system clock
`timescale 1ns/10ps

module iop_pwm
  import iop_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Duty value
  input  wire logic [7:0] duty,
  // Waveform
  output      logic       pwm_out
);

  iop_pwm_state_t st_r;
  iop_pwm_state_t st_nxt;
  logic [`IOP_POS_W-1:0]  pos;
  logic [`IOP_MCYC_W-1:0] mcyc;
  logic [`IOP_POS_W:0]    hi;

  // ----------------------------------------
  // Counter and compare
  // ----------------------------------------
  // Low bits walk the 64 clocks, top bits pick the modulation cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = 8'(st_r.cnt + 8'h01);                       // [RULE17] [RULE18]
    pos = st_nxt.cnt[`IOP_POS_W-1:0];
    mcyc = st_nxt.cnt[7:`IOP_POS_W];
    // Extra clock only while the cycle index is below the count
    hi = {1'b0, duty[7:`IOP_MCYC_W]}
       + {{`IOP_POS_W{1'b0}}, (mcyc < duty[`IOP_MCYC_W-1:0])}; // [RULE19] [RULE20]
    st_nxt.out = ({1'b0, pos} < hi);                         // [RULE22]
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign pwm_out = st_r.out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pwm_wrap: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
    ce && st_r.cnt == `IOP_CNT_TOP |=> st_r.cnt == `IOP_ZERO8)
    else $error("pulse counter did not wrap");
  a_pwm_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
    ce && duty == `IOP_ZERO8 |=> !pwm_out)
    else $error("pulse high with zero duty");
  a_pwm_start_high: assert property (@(posedge mclk) disable iff (rst) // [RULE22]
    ce && st_r.cnt[`IOP_POS_W-1:0] == `IOP_POS_TOP && duty[7:`IOP_MCYC_W] != 0
    |=> pwm_out)
    else $error("pulse not high at cycle start");
  a_pwm_end_low: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
    ce && st_r.cnt[`IOP_POS_W-1:0] == 6'h3E && duty[7:`IOP_MCYC_W] != `IOP_POS_TOP
    |=> !pwm_out)
    else $error("pulse high in last clock");

endmodule : iop_pwm

// file: logic/iop_top.sv
// Three bidirectional ports with tone and pulse-width outputs
`timescale 1ns/10ps

// Behaviour
// RULE1 - Port A, B, D data latches sit at 12H, 14H and 18H.
// RULE2 - Port reads sample pad levels directly at the read edge, no input latch. Reads here see the pads through two synchroniser stages.
// RULE3 - Written latch values hold until software writes that latch again.
// RULE4 - One direction bit per line: one is input, zero is push-pull output.
// RULE5 - Reads return pad level for input lines, latch for output lines.
// RULE6 - Port A, B, D direction registers sit at 13H, 15H and 19H.
// RULE7 - After reset no line is driven; it floats or is pulled high.
// RULE8 - Bit set, clear, complement read the port, modify, write latches back.
// RULE9 - Every port A line can wake the device from halt.
// RULE10 - Missing upper port B and D bits read zero, writes ignored.
// RULE11 - Each line has its own selectable pull-high option.
// RULE12 - Tone option drives tone on port A bit 3 in output mode only.
// RULE13 - With tone option, latch one passes tone, latch zero forces low.
// RULE14 - Tone runs at half the timer overflow rate.
// RULE15 - Port A bit 5 shares the interrupt pin, bit 4 the timer clock.
// RULE16 - Pulse option on output port D bit 0: latch one passes, zero forces low.
// RULE17 - Pulse generator uses 8-bit duty register at 1AH, counts system clock.
// RULE18 - Pulse cycle is four modulation cycles of 64 clocks each.
// RULE19 - Duty upper six bits are coarse value, lower two the extra count.
// RULE20 - Cycle i high time is coarse+1 when i below extra count, else coarse.
// RULE21 - Output driver enabled exactly when the direction bit is zero.
// RULE22 - Pulse is high from the first clock of each cycle for its high time.
module iop_top
  import iop_pkg::*;
#(
  parameter logic [`IOP_NLINES-1:0] PULL_OPT = '1
)(
  // Clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Core data-memory access
  input  wire iop_req_t               req,
  output      logic [7:0]             rdata,
  // Pads
  input  wire logic [`IOP_NLINES-1:0] pad_in,
  output      logic [`IOP_NLINES-1:0] pad_out,
  output      logic [`IOP_NLINES-1:0] pad_oe,
  output      logic [`IOP_NLINES-1:0] pull_en,
  // Options and timer
  input  wire logic                   tone_opt,
  input  wire logic                   pwm_opt,
  input  wire logic                   timer_ovf,
  input  wire logic                   halted,
  // Shared pin functions
  output      logic                   wake,
  output      logic                   irq_shared_pin,
  output      logic                   timer_clock_shared_pin
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Per-bit read source: pad for inputs, latch for outputs
  function automatic logic [7:0] iop_rd_mux(
    input logic [7:0] lat,
    input logic [7:0] dir,
    input logic [7:0] pad
  );
    iop_rd_mux = (dir & pad) | (~dir & lat);
  endfunction : iop_rd_mux

  // Bit operation applied to a freshly read byte
  function automatic logic [7:0] iop_rmw(
    input logic [7:0] val,
    input iop_op_t    op,
    input logic [2:0] sel
  );
    logic [7:0] mask;
    mask = 8'h01 << sel;
    case (op)
      IOP_OP_SET: iop_rmw = val | mask;
      IOP_OP_CLR: iop_rmw = val & ~mask;
      IOP_OP_CPL: iop_rmw = ~val;
      default:    iop_rmw = val;
    endcase
  endfunction : iop_rmw

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  iop_state_t             st_r;
  iop_state_t             st_nxt;
  logic                   pwm_wave;
  logic [7:0]             pad_a;
  logic [7:0]             pad_b;
  logic [7:0]             pad_d;
  logic [7:0]             rval;
  logic [7:0]             wval;
  logic                   do_wr;
  logic [`IOP_NLINES-1:0] lat;
  logic [`IOP_NLINES-1:0] dir;

  // ----------------------------------------
  // Pulse-width generator
  // ----------------------------------------
  iop_pwm u_pwm (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .duty    (st_r.duty),
    .pwm_out (pwm_wave)
  );

  // ----------------------------------------
  // Pad sampling and read path
  // ----------------------------------------
  // Pads come from outside: only the second stage feeds logic
  assign pad_a = st_r.sync2[`IOP_PA_HI:0];
  assign pad_b = {4'h0, st_r.sync2[`IOP_PB_HI:`IOP_PB_LO]};
  assign pad_d = {7'h00, st_r.sync2[`IOP_PD_BIT]};

  // Read value of the addressed location
  always_comb begin
    case (req.addr)
      `IOP_ADDR_PA_DATA: rval = iop_rd_mux(st_r.pa_d, st_r.pa_c, pad_a); // [RULE1] [RULE5]
      `IOP_ADDR_PA_DIR:  rval = st_r.pa_c;                                // [RULE6]
      `IOP_ADDR_PB_DATA: rval = iop_rd_mux({4'h0, st_r.pb_d},
                                           {4'h0, st_r.pb_c}, pad_b);     // [RULE10]
      `IOP_ADDR_PB_DIR:  rval = {4'h0, st_r.pb_c};                        // [RULE10]
      `IOP_ADDR_PD_DATA: rval = iop_rd_mux({7'h00, st_r.pd_d},
                                           {7'h00, st_r.pd_c}, pad_d);    // [RULE10]
      `IOP_ADDR_PD_DIR:  rval = {7'h00, st_r.pd_c};                       // [RULE10]
      `IOP_ADDR_DUTY:    rval = st_r.duty;                                // [RULE17]
      default:           rval = `IOP_ZERO8;
    endcase
  end

  // Plain write, or read-modify-write through the normal read source
  assign do_wr = req.wr | (req.op != IOP_OP_NONE);
  assign wval  = req.wr ? req.wdata : iop_rmw(rval, req.op, req.bit_sel); // [RULE8]

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1   = pad_in;
    st_nxt.sync2   = st_r.sync1;
    st_nxt.pa_prev = pad_a;

    // Read data takes the pads from the second synchroniser stage and holds them until the next read
    if (req.rd) begin
      st_nxt.rdata = rval;                                   // [RULE2]
    end

    // Latches change only on a write to their own address
    if (do_wr) begin
      case (req.addr)
        `IOP_ADDR_PA_DATA: st_nxt.pa_d = wval;                       // [RULE1] [RULE3]
        `IOP_ADDR_PA_DIR:  st_nxt.pa_c = wval;                       // [RULE6]
        `IOP_ADDR_PB_DATA: st_nxt.pb_d = wval[`IOP_PB_W-1:0];        // [RULE10]
        `IOP_ADDR_PB_DIR:  st_nxt.pb_c = wval[`IOP_PB_W-1:0];        // [RULE10]
        `IOP_ADDR_PD_DATA: st_nxt.pd_d = wval[`IOP_PD_W-1:0];        // [RULE10]
        `IOP_ADDR_PD_DIR:  st_nxt.pd_c = wval[`IOP_PD_W-1:0];        // [RULE10]
        `IOP_ADDR_DUTY:    st_nxt.duty = wval;                       // [RULE17]
        default:           st_nxt.duty = st_r.duty;
      endcase
    end

    // Toggle per overflow halves the overflow rate
    if (timer_ovf) begin
      st_nxt.tone = ~st_r.tone;                              // [RULE14]
    end

    // Drivers follow the latches; direction gates the enable
    lat = {st_nxt.pd_d, st_nxt.pb_d, st_nxt.pa_d};
    dir = {st_nxt.pd_c, st_nxt.pb_c, st_nxt.pa_c};
    st_nxt.out = lat;                                        // [RULE4]
    st_nxt.oe  = ~dir;                                       // [RULE4] [RULE21]

    // Latch acts as a gate on the shared functions
    if (tone_opt) begin
      st_nxt.out[`IOP_TONE_BIT] = lat[`IOP_TONE_BIT] & st_nxt.tone; // [RULE12] [RULE13]
    end
    if (pwm_opt) begin
      st_nxt.out[`IOP_PD_BIT] = lat[`IOP_PD_BIT] & pwm_wave;        // [RULE16]
    end

    // Mask option, fixed for the life of the part
    st_nxt.pull = PULL_OPT;                                  // [RULE11]

    // Any port A edge while halted wakes the core
    st_nxt.wake = halted & (|(pad_a ^ st_r.pa_prev));        // [RULE9]

    // Shared pin levels for the interrupt and timer logic
    st_nxt.irq = st_r.sync2[`IOP_IRQ_BIT];                   // [RULE15]
    st_nxt.tmr = st_r.sync2[`IOP_TMRCLK_BIT];                // [RULE15]
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset leaves all lines as inputs so nothing is driven
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.pa_d <= `IOP_PA_RST;
      st_r.pa_c <= `IOP_PA_RST;                              // [RULE7]
      st_r.pb_d <= `IOP_PB_RST;
      st_r.pb_c <= `IOP_PB_RST;                              // [RULE7]
      st_r.pd_d <= `IOP_PD_RST;
      st_r.pd_c <= `IOP_PD_RST;                              // [RULE7]
      st_r.duty <= `IOP_DUTY_RST;
      st_r.out  <= '1;
      st_r.pull <= PULL_OPT;                                 // [RULE11]
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All straight from the state register
  assign rdata                  = st_r.rdata;
  assign pad_out                = st_r.out;
  assign pad_oe                 = st_r.oe;
  assign pull_en                = st_r.pull;
  assign wake                   = st_r.wake;
  assign irq_shared_pin         = st_r.irq;
  assign timer_clock_shared_pin = st_r.tmr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_float: assert property (@(posedge mclk) // [RULE7]
    rst |=> pad_oe == '0)
    else $error("line driven after reset");

  a_oe_dir: assert property (@(posedge mclk) disable iff (rst) // [RULE21]
    pad_oe == ~{st_r.pd_c, st_r.pb_c, st_r.pa_c})
    else $error("driver enable disagrees with direction");

  a_pa_write: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
    ce && req.wr && req.addr == `IOP_ADDR_PA_DATA |=> st_r.pa_d == $past(req.wdata))
    else $error("port A latch missed write");

  a_pa_hold: assert property (@(posedge mclk) disable iff (rst) // [RULE3]
    !(ce && (req.wr || req.op != IOP_OP_NONE) && req.addr == `IOP_ADDR_PA_DATA)
    |=> $stable(st_r.pa_d))
    else $error("port A latch changed without write");

  a_dir_write: assert property (@(posedge mclk) disable iff (rst) // [RULE6]
    ce && req.wr && req.addr == `IOP_ADDR_PB_DIR
    |=> st_r.pb_c == $past(req.wdata[`IOP_PB_W-1:0]))
    else $error("port B direction missed write");

  a_pb_upper: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
    ce && req.rd && req.addr == `IOP_ADDR_PB_DATA |=> rdata[7:`IOP_PB_W] == 4'h0)
    else $error("missing port B bits read nonzero");

  a_read_src: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
    ce && req.rd && req.addr == `IOP_ADDR_PA_DATA
    |=> rdata == (($past(st_r.pa_c) & $past(pad_a)) | (~$past(st_r.pa_c) & $past(st_r.pa_d))))
    else $error("port A read source wrong");

  a_rmw_set: assert property (@(posedge mclk) disable iff (rst) // [RULE8]
    ce && !req.wr && req.op == IOP_OP_SET && req.addr == `IOP_ADDR_PA_DATA
    |=> st_r.pa_d[$past(req.bit_sel)])
    else $error("bit set did not land in latch");

  a_tone_toggle: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
    ce && timer_ovf |=> st_r.tone != $past(st_r.tone))
    else $error("tone did not toggle on overflow");

  a_tone_gate: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
    $past(ce) && $past(tone_opt) && pad_out[`IOP_TONE_BIT] |-> st_r.pa_d[`IOP_TONE_BIT])
    else $error("tone pin high with latch zero");

  a_pulse_gate: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
    $past(ce) && $past(pwm_opt) && pad_out[`IOP_PD_BIT] |-> st_r.pd_d[0])
    else $error("pulse pin high with latch zero");

  a_wake_cause: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
    wake |-> $past(halted))
    else $error("wake without halt");

endmodule : iop_top
